// file: hw/port0_port2_gpio.sv
// Port 0 and port 2 general-purpose I/O with analog pin selection
`timescale 1ns/10ps
module port0_port2_gpio (
    // Clock and reset
    input  wire logic                                   core_clk,
    input  wire logic                                   reset_n,
    // Register access
    input  wire port_gpio_pkg::reg_access_t             reg_acc,
    output logic [port_gpio_pkg::P2_WIDTH-1:0]          reg_rdata,
    // Port 0 pins
    input  wire logic [port_gpio_pkg::P0_WIDTH-1:0]     p0_pin_in,
    output logic [port_gpio_pkg::P0_WIDTH-1:0]          p0_pin_out,
    output logic [port_gpio_pkg::P0_WIDTH-1:0]          p0_pin_oe,
    output logic [port_gpio_pkg::P0_WIDTH-1:0]          p0_pullup_on,
    // Port 0 alternate functions
    input  wire logic                                   timer_out,
    input  wire logic                                   timer_out_en,
    output logic                                        timer_in,
    output logic [port_gpio_pkg::P0_WIDTH-1:0]          ext_irq_in,
    output logic                                        chip_select_in,
    // Port 2 pins
    input  wire logic [port_gpio_pkg::P2_WIDTH-1:0]     p2_pin_in,
    output port_gpio_pkg::pin_drive_t                   p2_drive,
    output logic [port_gpio_pkg::P2_WIDTH-1:0]          p2_dig_in_en,
    // Converter channel
    input  wire logic [port_gpio_pkg::CHAN_W-1:0]       converter_channel_select,
    output logic [port_gpio_pkg::P2_WIDTH-1:0]          analog_channel_input,
    output logic                                        config_prohibited
);
    import port_gpio_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic [P0_WIDTH-1:0] port0_data_latch_r, port0_data_latch_nxt;
    logic [P0_WIDTH-1:0] port0_direction_reg_r, port0_direction_reg_nxt;
    logic [P0_WIDTH-1:0] port0_pullup_enable_reg_r, port0_pullup_enable_reg_nxt;
    logic [P2_WIDTH-1:0] port2_data_latch_r, port2_data_latch_nxt;
    logic [P2_WIDTH-1:0] port2_direction_reg_r, port2_direction_reg_nxt;
    logic [P2_WIDTH-1:0] analog_digital_pin_select_r, analog_digital_pin_select_nxt;
    logic [P2_WIDTH-1:0] rdata_r, rdata_nxt;

    always_comb begin
        port0_data_latch_nxt          = port0_data_latch_r;
        port0_direction_reg_nxt       = port0_direction_reg_r;
        port0_pullup_enable_reg_nxt   = port0_pullup_enable_reg_r;
        port2_data_latch_nxt          = port2_data_latch_r;
        port2_direction_reg_nxt       = port2_direction_reg_r;
        analog_digital_pin_select_nxt = analog_digital_pin_select_r;
        if (reg_acc.wr) begin
            case (reg_acc.sel)
                SEL_P0_DATA: port0_data_latch_nxt = reg_acc.wdata[P0_WIDTH-1:0];
                SEL_P0_DIR:  port0_direction_reg_nxt = reg_acc.wdata[P0_WIDTH-1:0];
                SEL_P0_PULL: port0_pullup_enable_reg_nxt = reg_acc.wdata[P0_WIDTH-1:0];
                SEL_P2_DATA: port2_data_latch_nxt = reg_acc.wdata;
                SEL_P2_DIR:  port2_direction_reg_nxt = reg_acc.wdata;
                SEL_P2_ANA:  analog_digital_pin_select_nxt = reg_acc.wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [P0_WIDTH-1:0] p0_view;
    logic [P2_WIDTH-1:0] p2_view;

    always_comb begin
        // Inputs show the pin, outputs show the latch
        p0_view = (port0_direction_reg_r & p0_pin_in)
                | (~port0_direction_reg_r & port0_data_latch_r);
        // Analog input pins have the digital buffer off and read zero
        p2_view = (port2_direction_reg_r & p2_pin_in & ~analog_digital_pin_select_r)
                | (~port2_direction_reg_r & port2_data_latch_r);
        case (reg_acc.sel)
            SEL_P0_DATA: rdata_nxt = {{(P2_WIDTH-P0_WIDTH){1'b0}}, p0_view};
            SEL_P0_DIR:  rdata_nxt = {{(P2_WIDTH-P0_WIDTH){1'b0}}, port0_direction_reg_r};
            SEL_P0_PULL: rdata_nxt = {{(P2_WIDTH-P0_WIDTH){1'b0}},
                                      port0_pullup_enable_reg_r};
            SEL_P2_DATA: rdata_nxt = p2_view;
            SEL_P2_DIR:  rdata_nxt = port2_direction_reg_r;
            SEL_P2_ANA:  rdata_nxt = analog_digital_pin_select_r;
            default:     rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            port0_data_latch_r          <= P0_LATCH_RST;
            port0_direction_reg_r       <= P0_DIR_RST;
            port0_pullup_enable_reg_r   <= P0_PULL_RST;
            port2_data_latch_r          <= P2_LATCH_RST;
            port2_direction_reg_r       <= P2_DIR_RST;
            analog_digital_pin_select_r <= P2_ANA_RST;
            rdata_r                     <= 8'h00;
        end else begin
            port0_data_latch_r          <= port0_data_latch_nxt;
            port0_direction_reg_r       <= port0_direction_reg_nxt;
            port0_pullup_enable_reg_r   <= port0_pullup_enable_reg_nxt;
            port2_data_latch_r          <= port2_data_latch_nxt;
            port2_direction_reg_r       <= port2_direction_reg_nxt;
            analog_digital_pin_select_r <= analog_digital_pin_select_nxt;
            rdata_r                     <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ****************************************
    // Port 0 pins and alternate functions
    // ****************************************
    always_comb begin
        p0_pin_out = port0_data_latch_r;
        p0_pin_oe  = ~port0_direction_reg_r;
        // Timer output overrides the latch when timer_out_en is set and that pin is an output
        if (timer_out_en && !port0_direction_reg_r[P0_TMR_OUT_BIT])
            p0_pin_out[P0_TMR_OUT_BIT] = timer_out;
    end

    assign p0_pullup_on   = port0_pullup_enable_reg_r & port0_direction_reg_r;
    assign timer_in       = p0_pin_in[P0_TMR_IN_BIT];
    assign ext_irq_in     = p0_pin_in;
    assign chip_select_in = p0_pin_in[P0_CS_BIT];

    // ****************************************
    // Port 2 pin functions
    // ****************************************
    logic [P2_WIDTH-1:0] p2_oe, p2_prohib;

    genvar gi;
    generate
        for (gi = 0; gi < P2_WIDTH; gi++) begin : g_p2
            pin_fn_t fn;
            logic    hit;
            assign hit = (converter_channel_select == CHAN_W'(gi));
            port2_pin_func u_fn (
                .analog_sel (analog_digital_pin_select_r[gi]),
                .dir_input  (port2_direction_reg_r[gi]),
                .chan_hit   (hit),
                .fn         (fn),
                .drive_en   (p2_oe[gi]),
                .dig_in_en  (p2_dig_in_en[gi]),
                .conv_en    (analog_channel_input[gi])
            );
            assign p2_prohib[gi] = (fn == FN_PROHIBITED);
        end
    endgenerate

    assign p2_drive.out       = port2_data_latch_r;
    assign p2_drive.oe        = p2_oe;
    assign config_prohibited  = |p2_prohib;

    // ****************************************
    // Checks
    // ****************************************
    a_p0_reset_input: assert property (@(posedge core_clk)
        !reset_n |=> p0_pin_oe == 3'h0)
        else $error("port 0 driver on after reset");

    a_p0_dir_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_acc.wr && reg_acc.sel == SEL_P0_DIR
        |=> p0_pin_oe == ~$past(reg_acc.wdata[P0_WIDTH-1:0]))
        else $error("port 0 direction write not applied");

    a_p0_read_upper: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_acc.sel inside {SEL_P0_DATA, SEL_P0_DIR, SEL_P0_PULL}
        |=> reg_rdata[P2_WIDTH-1:P0_WIDTH] == 5'h00)
        else $error("port 0 read shows upper bits");

    a_p0_pullup_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        (p0_pullup_on & p0_pin_oe) == 3'h0)
        else $error("pull-up on while pin drives");

    a_p2_reset_analog: assert property (@(posedge core_clk)
        !reset_n |=> p2_dig_in_en == 8'h00 && p2_drive.oe == 8'h00)
        else $error("port 2 not analog input after reset");

    a_p2_analog_nodrive: assert property (@(posedge core_clk) disable iff (!reset_n)
        (p2_drive.oe & analog_digital_pin_select_r) == 8'h00)
        else $error("analog pin driven");

    a_p2_conv_onehot: assert property (@(posedge core_clk) disable iff (!reset_n)
        $onehot0(analog_channel_input))
        else $error("more than one pin converted");

    a_p2_conv_pick: assert property (@(posedge core_clk) disable iff (!reset_n)
        analog_channel_input == (analog_digital_pin_select_r & port2_direction_reg_r
                                 & (8'h01 << converter_channel_select)))
        else $error("selected analog input not converted");

    a_p2_prohib_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
        config_prohibited == |((~analog_digital_pin_select_r
                                & (8'h01 << converter_channel_select))
                               | (analog_digital_pin_select_r & ~port2_direction_reg_r)))
        else $error("prohibited pin setting not flagged");

    a_p2_dir_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_acc.wr && reg_acc.sel == SEL_P2_DIR
        |=> p2_drive.oe == (~$past(reg_acc.wdata) & ~analog_digital_pin_select_r))
        else $error("port 2 direction write not applied");

    a_p2_latch_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_acc.sel == SEL_P2_DATA && !reg_acc.wr
        |=> (reg_rdata & ~$past(port2_direction_reg_r))
            == ($past(port2_data_latch_r) & ~$past(port2_direction_reg_r)))
        else $error("output latch read wrong");

    a_rdata_none: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_acc.sel == SEL_NONE |=> reg_rdata == 8'h00)
        else $error("unused select read not zero");

    a_p0_latch_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_acc.wr && reg_acc.sel == SEL_P0_DATA && !timer_out_en
        |=> p0_pin_out == $past(reg_acc.wdata[P0_WIDTH-1:0]))
        else $error("port 0 latch write not applied");

endmodule

// file: hw/port2_pin_func.sv
// Per-pin function decoder for port 2
`timescale 1ns/10ps
module port2_pin_func (
    // Configuration of this pin
    input  wire logic                    analog_sel,
    input  wire logic                    dir_input,
    input  wire logic                    chan_hit,
    // Decoded function
    output port_gpio_pkg::pin_fn_t       fn,
    output logic                         drive_en,
    output logic                         dig_in_en,
    output logic                         conv_en
);
    import port_gpio_pkg::*;

    always_comb begin
        if (!analog_sel) begin
            if (chan_hit)
                fn = FN_PROHIBITED;
            else if (dir_input)
                fn = FN_DIG_IN;
            else
                fn = FN_DIG_OUT;
        end else begin
            if (!dir_input)
                fn = FN_PROHIBITED;
            else if (chan_hit)
                fn = FN_ANA_CONV;
            else
                fn = FN_ANA_IDLE;
        end
    end

    // Prohibited analog-output keeps the driver off to protect the converter
    assign drive_en  = !analog_sel && !dir_input;
    assign dig_in_en = !analog_sel;
    assign conv_en   = analog_sel && dir_input && chan_hit;

endmodule

// file: hw/port_gpio_pkg.sv
// Constants and carrier types for the port 0 / port 2 block
package port_gpio_pkg;

    localparam int P0_WIDTH = 3;
    localparam int P2_WIDTH = 8;
    localparam int CHAN_W   = 4;

    // Reset values: direction 1 = input, analog select 1 = analog
    localparam logic [P0_WIDTH-1:0] P0_DIR_RST   = 3'h7;
    localparam logic [P0_WIDTH-1:0] P0_PULL_RST  = 3'h0;
    localparam logic [P0_WIDTH-1:0] P0_LATCH_RST = 3'h0;
    localparam logic [P2_WIDTH-1:0] P2_DIR_RST   = 8'hff;
    localparam logic [P2_WIDTH-1:0] P2_LATCH_RST = 8'h00;
    localparam logic [P2_WIDTH-1:0] P2_ANA_RST   = 8'hff;

    // Port 0 bit positions of the alternate functions
    localparam int P0_TMR_IN_BIT  = 0;
    localparam int P0_TMR_OUT_BIT = 1;
    localparam int P0_CS_BIT      = 2;

    // Register selects of the write/read port
    typedef enum logic [2:0] {
        SEL_P0_DATA,
        SEL_P0_DIR,
        SEL_P0_PULL,
        SEL_P2_DATA,
        SEL_P2_DIR,
        SEL_P2_ANA,
        SEL_NONE
    } reg_sel_t;

    typedef struct packed {
        reg_sel_t              sel;
        logic                  wr;
        logic [P2_WIDTH-1:0]   wdata;
    } reg_access_t;

    // Per-pin drive bundle for one port
    typedef struct packed {
        logic [P2_WIDTH-1:0] out;
        logic [P2_WIDTH-1:0] oe;
    } pin_drive_t;

    // Per-pin function decoded for port 2
    typedef enum logic [2:0] {
        FN_DIG_IN,
        FN_DIG_OUT,
        FN_ANA_CONV,
        FN_ANA_IDLE,
        FN_PROHIBITED
    } pin_fn_t;

endpackage

// file: testbench/port0_port2_gpio_tb.sv
// Self-checking bench for the port 0 / port 2 block
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module port0_port2_gpio_tb;
    import port_gpio_pkg::*;
    logic        core_clk, reset_n, timer_out, timer_out_en, timer_in, chip_select_in;
    logic        config_prohibited;
    reg_access_t reg_acc;
    pin_drive_t  p2_drive;
    logic [7:0]  reg_rdata, p2_dig_in_en, analog_channel_input, p2_pin_in, b2_val, l2, d2, a2;
    logic [7:0]  oh;
    logic [2:0]  p0_pin_in, p0_pin_out, p0_pin_oe, p0_pullup_on, ext_irq_in, b0_val, b0_en;
    logic [2:0]  l0, d0, u0, lv0;
    logic [3:0]  converter_channel_select;
    logic [31:0] seed = 32'h5d;
    logic [31:0] v;
    int          n_fail = 0;
    int          n_checks = 0;

    port0_port2_gpio u_dut (.core_clk, .reset_n, .reg_acc, .reg_rdata, .p0_pin_in, .p0_pin_out,
        .p0_pin_oe, .p0_pullup_on, .timer_out, .timer_out_en, .timer_in, .ext_irq_in,
        .chip_select_in, .p2_pin_in, .p2_drive, .p2_dig_in_en, .converter_channel_select,
        .analog_channel_input, .config_prohibited);
    port_board u_board (.core_clk, .p0_out(p0_pin_out), .p0_oe(p0_pin_oe), .p0_pull(p0_pullup_on),
        .p2_out(p2_drive.out), .p2_oe(p2_drive.oe), .b0_val, .b0_en, .b2_val,
        .p0_lvl(p0_pin_in), .p2_lvl(p2_pin_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wr(input reg_sel_t s, input logic [7:0] d);
        reg_acc = '{s, 1'b1, d};
        @(negedge core_clk);
    endtask

    task automatic rd(input reg_sel_t s, input logic [7:0] e, input logic [7:0] m);
        reg_acc = '{s, 1'b0, 8'h00};
        @(negedge core_clk);
        `CHK(reg_rdata & m, e & m)
    endtask

    task automatic check_all();
        oh = (converter_channel_select < 4'h8) ? 8'h01 << converter_channel_select : 8'h00;
        lv0 = b0_en & b0_val | ~b0_en & u0;
        `CHK(p0_pin_oe, ~d0)
        `CHK(p0_pullup_on, u0 & d0)
        `CHK(p0_pin_out, {l0[2], (timer_out_en & ~d0[1]) ? timer_out : l0[1], l0[0]})
        `CHK({timer_in, chip_select_in, ext_irq_in}, {p0_pin_in[0], p0_pin_in[2], p0_pin_in})
        `CHK(p2_drive.out, l2)
        `CHK(p2_drive.oe, ~d2 & ~a2)
        `CHK(p2_dig_in_en, ~a2)
        `CHK(analog_channel_input, a2 & d2 & oh)
        `CHK(config_prohibited, |(~a2 & oh) | |(a2 & ~d2))
        rd(SEL_NONE, 8'h00, 8'hff);
        rd(SEL_P0_DATA, {5'h00, d0 & lv0 | ~d0 & l0}, {5'h1f, ~(d0 & ~b0_en & ~u0)});
        rd(SEL_P2_DATA, d2 & b2_val & ~a2 | ~d2 & l2, 8'hff);
        rd(SEL_P0_PULL, {5'h00, u0}, 8'hff);
        rd(SEL_P0_DIR, {5'h00, d0}, 8'hff);
        rd(SEL_P2_DIR, d2, 8'hff);
        rd(SEL_P2_ANA, a2, 8'hff);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        reg_acc = '{SEL_NONE, 1'b0, 8'h00};
        {timer_out, timer_out_en, converter_channel_select} = 6'h00;
        {b0_val, b0_en, b2_val} = 14'h0000;
        {d0, u0, l0} = {P0_DIR_RST, P0_PULL_RST, P0_LATCH_RST};
        {d2, a2, l2} = {P2_DIR_RST, P2_ANA_RST, P2_LATCH_RST};
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        check_all();
        for (int i = 0; i < 200; i++) begin
            v = rnd();
            {d0, u0, l0} = v[8:0];
            {d2, a2, l2} = {v[31:24], v[23:16], v[15:8]};
            if (i < 4) begin
                a2 = {8{i[0]}};
                d2 = {8{i[1]}};
            end
            if (i == 4) {a2, d2} = {8'hf0, d2 | 8'hf0};
            wr(SEL_P0_DIR, {5'h00, d0});
            wr(SEL_P0_PULL, {5'h00, u0});
            wr(SEL_P0_DATA, {5'h00, l0});
            wr(SEL_P2_DIR, d2);
            wr(SEL_P2_ANA, a2);
            wr(SEL_P2_DATA, l2);
            v = rnd();
            {b0_val, b0_en, b2_val, converter_channel_select, timer_out, timer_out_en} = v[27:8];
            // Pin levels settle for a full cycle before the compares
            wr(SEL_NONE, v[7:0]);
            check_all();
        end
        // Second reset from a random configuration
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        {d0, u0, l0} = {P0_DIR_RST, P0_PULL_RST, P0_LATCH_RST};
        {d2, a2, l2} = {P2_DIR_RST, P2_ANA_RST, P2_LATCH_RST};
        check_all();
        results();
    end
endmodule

// file: testbench/port_board.sv
// Board model resolving the port 0 and port 2 pin levels
`timescale 1ns/10ps
module port_board (
    // Clock
    input  wire logic       core_clk,
    // Device side
    input  wire logic [2:0] p0_out,
    input  wire logic [2:0] p0_oe,
    input  wire logic [2:0] p0_pull,
    input  wire logic [7:0] p2_out,
    input  wire logic [7:0] p2_oe,
    // Board side
    input  wire logic [2:0] b0_val,
    input  wire logic [2:0] b0_en,
    input  wire logic [7:0] b2_val,
    // Resolved levels
    output logic      [2:0] p0_lvl,
    output logic      [7:0] p2_lvl
);
    logic [2:0] flt_r = 3'h5;
    // Floating pins wander each cycle
    always_ff @(posedge core_clk) flt_r <= ~flt_r;
    always_comb begin
        p0_lvl = p0_oe & p0_out | ~p0_oe & (b0_en & b0_val | ~b0_en & (p0_pull | flt_r));
        p2_lvl = p2_oe & p2_out | ~p2_oe & b2_val;
    end
endmodule
